// ### rtl/adsq_pkg.sv
// constants, types and register map of the converter sequencer control
package adsq_pkg;
  localparam logic [19:0] ADDR_RES_A_HI = 20'hFFFE0;
  localparam logic [19:0] ADDR_RES_A_LO = 20'hFFFE1;
  localparam logic [19:0] ADDR_RES_B_HI = 20'hFFFE2;
  localparam logic [19:0] ADDR_RES_B_LO = 20'hFFFE3;
  localparam logic [19:0] ADDR_RES_C_HI = 20'hFFFE4;
  localparam logic [19:0] ADDR_RES_C_LO = 20'hFFFE5;
  localparam logic [19:0] ADDR_RES_D_HI = 20'hFFFE6;
  localparam logic [19:0] ADDR_RES_D_LO = 20'hFFFE7;
  localparam logic [19:0] ADDR_CSR = 20'hFFFE8;
  localparam logic [19:0] ADDR_TRG = 20'hFFFE9;

  localparam int CSR_FLAG_BIT = 7;
  localparam int CSR_IE_BIT = 6;
  localparam int CSR_RUN_BIT = 5;
  localparam int CSR_SCAN_BIT = 4;
  localparam int CSR_SPEED_BIT = 3;
  localparam int CSR_GROUP_BIT = 2;
  localparam int TRG_EN_BIT = 7;
  localparam int TRG_SPARE_BIT = 0;

  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] TRG_RESET = 8'h7E;
  localparam logic [5:0] TRG_RSVD_ONES = 6'h3F;
  localparam logic [9:0] RES_RESET = 10'h000;
  localparam logic [5:0] RES_LO_PAD = 6'h00;
  localparam logic [7:0] BUS_IDLE_DATA = 8'h00;

  // one state is one system clock
  localparam int CLK_PER_STATE = 1;
  localparam int CONV_SLOW_STATES = 134;
  localparam int CONV_FAST_STATES = 70;
  localparam int SCAN_SLOW_STATES = 128;
  localparam int SCAN_FAST_STATES = 66;
  localparam logic [7:0] CONV_SLOW_CYC = 8'(CONV_SLOW_STATES * CLK_PER_STATE);
  localparam logic [7:0] CONV_FAST_CYC = 8'(CONV_FAST_STATES * CLK_PER_STATE);
  localparam logic [7:0] SCAN_SLOW_CYC = 8'(SCAN_SLOW_STATES * CLK_PER_STATE);
  localparam logic [7:0] SCAN_FAST_CYC = 8'(SCAN_FAST_STATES * CLK_PER_STATE);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_SCAN = 3'b100
  } adsq_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [19:0] addr;
    logic [7:0] wdata;
  } adsq_bus_t;

  typedef struct packed {
    logic active;
    logic [2:0] channel;
  } adsq_conv_t;
endpackage

// ### rtl/adsq_trig_sync.sv
// three-stage synchroniser and falling-edge detector for the trigger pin
`timescale 1ns/10ps
module adsq_trig_sync (
  input logic mclk_i,
  input logic sys_rst_i,
  input logic pin_i,
  output logic fall_o
);
  logic s1_r, s2_r, s3_r, level_r, fall_r;
  logic level_nxt, fall_nxt;

  // a change counts only once stages two and three agree
  always_comb begin
    level_nxt = level_r;
    fall_nxt = 1'b0;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
      fall_nxt = level_r & ~s3_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_r <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign fall_o = fall_r;

  one_pulse_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    fall_r |=> !fall_r) else $error("trigger edge pulse longer than one cycle");
endmodule

// ### rtl/adsq_result_mem.sv
// four-word result store with registered read port
`timescale 1ns/10ps
module adsq_result_mem (
  input logic mclk_i,
  input logic sys_rst_i,
  input logic clr_i,
  input logic wr_en_i,
  input logic [1:0] wr_idx_i,
  input logic [9:0] wr_data_i,
  input logic [1:0] rd_idx_i,
  output logic [9:0] rd_data_o
);
  logic [9:0] mem_r [4];
  logic [9:0] mem_nxt [4];
  logic [9:0] q_r, q_nxt;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mem_nxt[i] = mem_r[i];
      if (clr_i) begin
        mem_nxt[i] = adsq_pkg::RES_RESET;
      end else if (wr_en_i && wr_idx_i == 2'(i)) begin
        mem_nxt[i] = wr_data_i;
      end
    end
    q_nxt = clr_i ? adsq_pkg::RES_RESET : mem_r[rd_idx_i];
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= adsq_pkg::RES_RESET;
      end
      q_r <= adsq_pkg::RES_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
      q_r <= q_nxt;
    end
  end

  assign rd_data_o = q_r;

  clear_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clr_i |=> mem_r[0] == 10'h000 && mem_r[3] == 10'h000) else $error("standby left a result");
endmodule

// ### rtl/adsq_ctrl.sv
// converter sequencer control: registers, start logic, sequencing, result reads
`timescale 1ns/10ps
module adsq_ctrl (
  input logic mclk_i,
  input logic sys_rst_i,
  input logic standby_i,
  input adsq_pkg::adsq_bus_t bus_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input logic ext_trigger_in_i,
  input logic timer_match_i,
  input logic [9:0] conv_result_i,
  output adsq_pkg::adsq_conv_t conv_o,
  output logic conversion_done_irq_o
);
  adsq_pkg::adsq_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic flag_r, flag_nxt;
  logic ie_r, ie_nxt;
  logic run_r, run_nxt;
  logic scan_r, scan_nxt;
  logic speed_r, speed_nxt;
  logic [2:0] chsel_r, chsel_nxt;
  logic armed_r, armed_nxt;
  logic trg_en_r, trg_en_nxt;
  logic trg_spare_r, trg_spare_nxt;

  logic rd_hi_r, rd_lo_r, rd_csr_r, rd_trg_r, rd_any_r;
  logic [7:0] temp_r, temp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r;

  logic csr_sel, trg_sel, hi_sel, lo_sel;
  logic csr_wr, trg_wr;
  logic trig_fall, hw_start;
  logic conv_end, res_wr, set_flag;
  logic [2:0] first_ch;
  logic [7:0] first_len, scan_len;
  logic [9:0] mem_q;
  logic [7:0] csr_val, trg_val;

  adsq_trig_sync u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(ext_trigger_in_i),
    .fall_o(trig_fall)
  );

  adsq_result_mem u_mem (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(standby_i),
    .wr_en_i(res_wr),
    .wr_idx_i(chan_r[1:0]),
    .wr_data_i(conv_result_i),
    .rd_idx_i(bus_i.addr[2:1]),
    .rd_data_o(mem_q)
  );

  always_comb begin
    csr_sel = bus_i.addr == adsq_pkg::ADDR_CSR;
    trg_sel = bus_i.addr == adsq_pkg::ADDR_TRG;
    case (bus_i.addr)
      adsq_pkg::ADDR_RES_A_HI, adsq_pkg::ADDR_RES_B_HI,
      adsq_pkg::ADDR_RES_C_HI, adsq_pkg::ADDR_RES_D_HI: begin
        hi_sel = 1'b1;
        lo_sel = 1'b0;
      end
      adsq_pkg::ADDR_RES_A_LO, adsq_pkg::ADDR_RES_B_LO,
      adsq_pkg::ADDR_RES_C_LO, adsq_pkg::ADDR_RES_D_LO: begin
        hi_sel = 1'b0;
        lo_sel = 1'b1;
      end
      default: begin
        hi_sel = 1'b0;
        lo_sel = 1'b0;
      end
    endcase
  end

  assign csr_wr = bus_i.wr & csr_sel;
  assign trg_wr = bus_i.wr & trg_sel;
  assign csr_val = {flag_r, ie_r, run_r, scan_r, speed_r, chsel_r};
  assign trg_val = {trg_en_r, adsq_pkg::TRG_RSVD_ONES, trg_spare_r};

  // control, start and sequencing
  always_comb begin
    hw_start = trg_en_r & (trig_fall | timer_match_i);
    // scan begins at the group start, single at the chosen input
    first_ch = scan_r ? {chsel_r[2], 2'b00} : chsel_r;
    first_len = speed_r ? adsq_pkg::CONV_FAST_CYC : adsq_pkg::CONV_SLOW_CYC;
    scan_len = speed_r ? adsq_pkg::SCAN_FAST_CYC : adsq_pkg::SCAN_SLOW_CYC;
    conv_end = state_r != adsq_pkg::ST_IDLE && run_r && cnt_r == 8'h00;
    res_wr = conv_end & ~standby_i;
    // scan: the channel field is also the last channel of the cycle
    set_flag = conv_end & (~scan_r | chan_r == chsel_r);
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    chan_nxt = chan_r;
    case (state_r)
      adsq_pkg::ST_IDLE: begin
        if (run_r) begin
          state_nxt = adsq_pkg::ST_FIRST;
          cnt_nxt = first_len - 8'h01;
          chan_nxt = first_ch;
        end
      end
      adsq_pkg::ST_FIRST, adsq_pkg::ST_SCAN: begin
        if (!run_r) begin
          state_nxt = adsq_pkg::ST_IDLE;
        end else if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else if (!scan_r) begin
          state_nxt = adsq_pkg::ST_IDLE;
        end else begin
          state_nxt = adsq_pkg::ST_SCAN;
          cnt_nxt = scan_len - 8'h01;
          chan_nxt = (chan_r == chsel_r) ? {chsel_r[2], 2'b00} : chan_r + 3'h1;
        end
      end
      default: begin
        state_nxt = adsq_pkg::ST_IDLE;
      end
    endcase

    ie_nxt = ie_r;
    scan_nxt = scan_r;
    speed_nxt = speed_r;
    chsel_nxt = chsel_r;
    run_nxt = run_r;
    flag_nxt = flag_r;
    armed_nxt = armed_r;
    trg_en_nxt = trg_en_r;
    trg_spare_nxt = trg_spare_r;
    if (conv_end && !scan_r) begin
      run_nxt = 1'b0;
    end
    if (bus_i.rd && csr_sel && flag_r) begin
      armed_nxt = 1'b1;
    end
    if (csr_wr) begin
      ie_nxt = bus_i.wdata[adsq_pkg::CSR_IE_BIT];
      run_nxt = bus_i.wdata[adsq_pkg::CSR_RUN_BIT];
      scan_nxt = bus_i.wdata[adsq_pkg::CSR_SCAN_BIT];
      speed_nxt = bus_i.wdata[adsq_pkg::CSR_SPEED_BIT];
      chsel_nxt = bus_i.wdata[adsq_pkg::CSR_GROUP_BIT:0];
      armed_nxt = 1'b0;
      // only a zero after a read of one clears; a one is ignored
      if (armed_r && !bus_i.wdata[adsq_pkg::CSR_FLAG_BIT]) begin
        flag_nxt = 1'b0;
      end
    end
    if (trg_wr) begin
      trg_en_nxt = bus_i.wdata[adsq_pkg::TRG_EN_BIT];
      trg_spare_nxt = bus_i.wdata[adsq_pkg::TRG_SPARE_BIT];
    end
    // hardware set wins over a bus-write or end-of-conversion clear in the same cycle; standby wins over it
    if (hw_start) begin
      run_nxt = 1'b1;
    end
    if (set_flag) begin
      flag_nxt = 1'b1;
    end
    if (standby_i) begin
      state_nxt = adsq_pkg::ST_IDLE;
      cnt_nxt = 8'h00;
      chan_nxt = 3'h0;
      {flag_nxt, ie_nxt, run_nxt, scan_nxt, speed_nxt, chsel_nxt} = adsq_pkg::CSR_RESET;
      armed_nxt = 1'b0;
      trg_en_nxt = adsq_pkg::TRG_RESET[adsq_pkg::TRG_EN_BIT];
      trg_spare_nxt = adsq_pkg::TRG_RESET[adsq_pkg::TRG_SPARE_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r <= adsq_pkg::ST_IDLE;
      cnt_r <= 8'h00;
      chan_r <= 3'h0;
      {flag_r, ie_r, run_r, scan_r, speed_r, chsel_r} <= adsq_pkg::CSR_RESET;
      armed_r <= 1'b0;
      trg_en_r <= adsq_pkg::TRG_RESET[adsq_pkg::TRG_EN_BIT];
      trg_spare_r <= adsq_pkg::TRG_RESET[adsq_pkg::TRG_SPARE_BIT];
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      chan_r <= chan_nxt;
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      run_r <= run_nxt;
      scan_r <= scan_nxt;
      speed_r <= speed_nxt;
      chsel_r <= chsel_nxt;
      armed_r <= armed_nxt;
      trg_en_r <= trg_en_nxt;
      trg_spare_r <= trg_spare_nxt;
    end
  end

  // read path: stage one fetches the word, stage two returns the byte
  always_comb begin
    temp_nxt = temp_r;
    rdata_nxt = adsq_pkg::BUS_IDLE_DATA;
    if (rd_hi_r) begin
      rdata_nxt = mem_q[9:2];
      temp_nxt = {mem_q[1:0], adsq_pkg::RES_LO_PAD};
    end else if (rd_lo_r) begin
      rdata_nxt = temp_r;
    end else if (rd_csr_r) begin
      rdata_nxt = csr_val;
    end else if (rd_trg_r) begin
      rdata_nxt = trg_val;
    end
    if (standby_i) begin
      temp_nxt = 8'h00;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rd_hi_r <= 1'b0;
      rd_lo_r <= 1'b0;
      rd_csr_r <= 1'b0;
      rd_trg_r <= 1'b0;
      rd_any_r <= 1'b0;
      temp_r <= 8'h00;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rd_hi_r <= bus_i.rd & hi_sel;
      rd_lo_r <= bus_i.rd & lo_sel;
      rd_csr_r <= bus_i.rd & csr_sel;
      rd_trg_r <= bus_i.rd & trg_sel;
      rd_any_r <= bus_i.rd;
      temp_r <= temp_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rd_any_r;
    end
  end

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign conv_o.active = state_r != adsq_pkg::ST_IDLE;
  assign conv_o.channel = chan_r;
  // level request, no latching of its own
  assign conversion_done_irq_o = flag_r & ie_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  single_end_a: assert property (conv_end && !scan_r && !standby_i && !hw_start
    && !csr_wr |=> flag_r && !run_r && state_r == adsq_pkg::ST_IDLE)
    else $error("single end did not set flag and stop");
  flag_hold_a: assert property (flag_r && csr_wr && bus_i.wdata[7] && !standby_i
    |=> flag_r) else $error("writing one cleared the flag");
  flag_noread_a: assert property (flag_r && !armed_r && !standby_i |=> flag_r)
    else $error("flag cleared without prior read");
  irq_gate_a: assert property (!ie_r |-> !conversion_done_irq_o)
    else $error("interrupt raised while disabled");
  hw_start_a: assert property (trg_en_r && timer_match_i && !standby_i |=> run_r)
    else $error("timer match did not start");
  hw_block_a: assert property (!trg_en_r && !run_r && !csr_wr |=> !run_r)
    else $error("start without trigger enable");
  start_chan_a: assert property (state_r == adsq_pkg::ST_IDLE && run_r && !standby_i
    |=> chan_r == $past(first_ch) && state_r == adsq_pkg::ST_FIRST)
    else $error("wrong first channel");
  first_len_a: assert property (state_r == adsq_pkg::ST_IDLE && run_r && !standby_i
    && !speed_r |=> cnt_r == 8'd133) else $error("slow first length wrong");
  scan_len_a: assert property (conv_end && scan_r && speed_r && !standby_i
    |=> cnt_r == 8'd65) else $error("fast scan length wrong");
  lo_pad_a: assert property (rd_hi_r && !standby_i
    |=> temp_r[5:0] == 6'h00 && temp_r[7:6] == $past(mem_q[1:0]))
    else $error("holder not loaded from low bits");
  hi_byte_a: assert property (rd_hi_r |=> rdata_r == $past(mem_q[9:2]))
    else $error("high byte wrong");
  standby_a: assert property (standby_i
    |=> csr_val == 8'h00 && state_r == adsq_pkg::ST_IDLE)
    else $error("standby did not clear control");
  first_fast_a: assert property (state_r == adsq_pkg::ST_IDLE && run_r && !standby_i
    && speed_r |=> cnt_r == 8'd69) else $error("fast first length wrong");
  scan_slow_a: assert property (conv_end && scan_r && !speed_r && !standby_i
    |=> cnt_r == 8'd127) else $error("slow scan length wrong");
  scan_first_a: assert property (state_r == adsq_pkg::ST_IDLE && run_r && scan_r
    && !standby_i |=> chan_r == {$past(chsel_r[2]), 2'b00})
    else $error("scan did not start at group start");
  scan_keep_a: assert property (conv_end && scan_r && !standby_i && !csr_wr
    |=> run_r && state_r == adsq_pkg::ST_SCAN) else $error("scan stopped by itself");
  scan_wrap_a: assert property (conv_end && scan_r && chan_r == chsel_r && !standby_i
    && !csr_wr |=> chan_r == {chsel_r[2], 2'b00}) else $error("scan did not wrap");
  scan_step_a: assert property (conv_end && scan_r && chan_r != chsel_r && !standby_i
    |=> chan_r == $past(chan_r) + 3'h1) else $error("scan skipped a channel");
  scan_flag_a: assert property (conv_end && scan_r && chan_r != chsel_r && !flag_r
    && !standby_i |=> !flag_r) else $error("flag set before scan cycle ended");
  run_stop_a: assert property (!run_r && state_r != adsq_pkg::ST_IDLE
    |=> state_r == adsq_pkg::ST_IDLE) else $error("conversion went on after stop");
  holder_read_a: assert property (rd_lo_r |=> rdata_r == $past(temp_r))
    else $error("low byte not from holder");
  csr_read_a: assert property (rd_csr_r |=> rdata_r == $past(csr_val))
    else $error("status read wrong");
  lo_zero_a: assert property (rvalid_o && $past(rd_lo_r) |-> rdata_o[5:0] == 6'h00)
    else $error("low byte padding not zero");
  trig_start_a: assert property (trg_en_r && trig_fall && !standby_i |=> run_r)
    else $error("trigger fall did not start");
endmodule

// ### test/adsq_conv_model.sv
// behavioural converter front end: a result per channel, scrambled when idle
`timescale 1ns/10ps
module adsq_conv_model (
  input wire mclk_i,
  input adsq_pkg::adsq_conv_t conv_i,
  output logic [9:0] result_o
);
  logic [9:0] last_r = 10'h000;
  always_ff @(posedge mclk_i) begin
    last_r <= result_o;
  end
  // idle value flips every cycle so a sample one cycle late reads the inverted result
  always_comb begin
    if (conv_i.active === 1'b1) begin
      result_o = 10'(conv_i.channel) * 10'h07B + 10'h155;
    end else begin
      result_o = ~last_r;
    end
  end
endmodule

// ### test/testbench.sv
// self-checking bench for the converter sequencer control
`timescale 1ns/10ps
module testbench;
  localparam logic [19:0] CSR = adsq_pkg::ADDR_CSR;
  localparam logic [19:0] TRG = adsq_pkg::ADDR_TRG;
  localparam logic [19:0] RES = adsq_pkg::ADDR_RES_A_HI;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic standby = 1'b0;
  adsq_pkg::adsq_bus_t bus = '0;
  logic ext_trig = 1'b1;
  logic timer_match = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic [9:0] conv_result;
  adsq_pkg::adsq_conv_t conv;
  logic irq;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  logic prev_act = 1'b0;
  logic [2:0] prev_ch = 3'h0;
  int seg_len = 0;
  logic [2:0] seg_ch[$];
  int seg_n[$];
  wire act = (conv.active === 1'b1);

  adsq_ctrl u_adsq_ctrl (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .standby_i(standby),
    .bus_i(bus), .rdata_o(rdata), .rvalid_o(rvalid), .ext_trigger_in_i(ext_trig),
    .timer_match_i(timer_match), .conv_result_i(conv_result), .conv_o(conv),
    .conversion_done_irq_o(irq));
  adsq_conv_model u_adsq_conv_model (.mclk_i(mclk_i), .conv_i(conv), .result_o(conv_result));

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  // conversion segments logged on the falling edge, clear of input updates
  always @(negedge mclk_i) begin
    if (prev_act && (!act || conv.channel != prev_ch)) begin
      seg_ch.push_back(prev_ch);
      seg_n.push_back(seg_len);
    end
    seg_len = (act && prev_act && conv.channel == prev_ch) ? seg_len + 1 : 1;
    prev_act = act;
    prev_ch = conv.channel;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      $display("unexpected timeout expected 10000 seen %0d", cycles);
      give_verdict();
    end
  end

  function automatic logic [9:0] exp_res(input logic [2:0] ch);
    return 10'(ch) * 10'h07B + 10'h155;
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_len(input string what, input int exp, input int seen);
    n_checks++;
    if (seen != exp) begin
      n_fail++;
      $display("unexpected %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask

  // answer comes one edge after the edge that takes the request; look a little beyond
  task automatic rd_chk(input string what, input logic [19:0] a, input logic [7:0] exp);
    logic [7:0] d;
    d = 'x;
    @(posedge mclk_i);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      #1;
      if (rvalid === 1'b1) begin
        d = rdata;
        break;
      end
    end
    chk(what, exp, d);
  endtask

  task automatic next_seg(input logic [2:0] ch, input int len);
    for (int i = 0; i < 1000 && seg_n.size() == 0; i++) @(posedge mclk_i);
    @(negedge mclk_i);
    if (seg_n.size() == 0) begin
      chk_len("conversion count", 1, 0);
    end else begin
      chk("conversion channel", 8'(ch), 8'(seg_ch.pop_front()));
      chk_len("conversion length", len, seg_n.pop_front());
    end
  endtask

  task automatic single_test();
    logic [7:0] c;
    logic [9:0] v;
    for (int ch = 0; ch < 8; ch++) begin
      c = 8'h40 | (ch[0] ? 8'h08 : 8'h00) | 8'(ch);
      v = exp_res(3'(ch));
      wr(CSR, c | 8'h20);
      next_seg(3'(ch), ch[0] ? 70 : 134);
      wr(CSR, c);
      rd_chk("flag kept without read", CSR, c | 8'h80);
      wr(CSR, c | 8'h80);
      rd_chk("flag after writing one", CSR, c | 8'h80);
      chk("done irq", 8'h01, 8'(irq));
      wr(CSR, c & 8'hBF | 8'h80);
      @(negedge mclk_i);
      chk("masked irq", 8'h00, 8'(irq));
      rd_chk("flag masked", CSR, c & 8'hBF | 8'h80);
      wr(CSR, c & 8'h3F);
      rd_chk("flag cleared", CSR, c & 8'h3F);
      rd_chk("result high", RES + 20'(2 * (ch % 4)), v[9:2]);
      rd_chk("result low", RES + 20'(2 * (ch % 4) + 1), {v[1:0], 6'h00});
    end
    wr(RES + 20'h6, 8'h00);
    rd_chk("read-only result", RES + 20'h6, exp_res(3'h7) >> 2);
  endtask

  task automatic scan_test();
    seg_ch.delete();
    seg_n.delete();
    wr(CSR, 8'h3E);
    next_seg(3'h4, 70);
    rd_chk("scan flag early", CSR, 8'h3E);
    next_seg(3'h5, 66);
    next_seg(3'h6, 66);
    next_seg(3'h4, 66);
    wr(CSR, 8'h1E);
    repeat (200) @(posedge mclk_i);
    chk_len("conversions after stop", 1, seg_n.size());
    rd_chk("scan flag", CSR, 8'h9E);
    for (int i = 0; i < 3; i++) rd_chk("scan result", RES + 20'(2 * i), exp_res(3'(4 + i)) >> 2);
    seg_ch.delete();
    seg_n.delete();
    wr(CSR, 8'h3E);
    next_seg(3'h4, 70);
    wr(CSR, 8'h1E);
    rd_chk("scan flag cleared", CSR, 8'h1E);
    seg_ch.delete();
    seg_n.delete();
    wr(CSR, 8'h31);
    next_seg(3'h0, 134);
    next_seg(3'h1, 128);
    rd_chk("group 0 scan flag", CSR, 8'hB1);
    wr(CSR, 8'h00);
    rd_chk("group 0 flag cleared", CSR, 8'h00);
  endtask

  task automatic trig_test();
    seg_ch.delete();
    seg_n.delete();
    wr(TRG, 8'h00);
    rd_chk("trigger ctrl", TRG, 8'h7E);
    ext_trig <= 1'b0;
    timer_match <= 1'b1;
    @(posedge mclk_i);
    timer_match <= 1'b0;
    repeat (20) @(posedge mclk_i);
    ext_trig <= 1'b1;
    rd_chk("no hardware start", CSR, 8'h00);
    wr(TRG, 8'h80);
    rd_chk("trigger ctrl", TRG, 8'hFE);
    ext_trig <= 1'b0;
    next_seg(3'h0, 134);
    repeat (40) @(posedge mclk_i);
    chk_len("starts per fall", 0, seg_n.size());
    ext_trig <= 1'b1;
    rd_chk("trigger flag", CSR, 8'h80);
    wr(CSR, 8'h00);
    timer_match <= 1'b1;
    @(posedge mclk_i);
    timer_match <= 1'b0;
    next_seg(3'h0, 134);
  endtask

  task automatic standby_test();
    wr(CSR, 8'h61);
    repeat (30) @(posedge mclk_i);
    standby <= 1'b1;
    @(posedge mclk_i);
    standby <= 1'b0;
    @(negedge mclk_i);
    chk("active after standby", 8'h00, 8'(conv.active));
    rd_chk("csr after standby", CSR, 8'h00);
    rd_chk("trigger after standby", TRG, 8'h7E);
    for (int i = 0; i < 4; i++) rd_chk("result after standby", RES + 20'(2 * i), 8'h00);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 11; i++) rd_chk("reset value", RES + 20'(i), i == 9 ? 8'h7E : 8'h00);
    $display("test reset values done");
    single_test();
    $display("test single mode done");
    scan_test();
    $display("test scan mode done");
    trig_test();
    $display("test hardware start done");
    standby_test();
    $display("test standby done");
    give_verdict();
  end
endmodule
